// file: verilog/pss_params.svh
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH
// timing figures in their own units
`define PSS_CLK_HZ 25000000
`define PSS_SETTLE_MS 2
`define PSS_MS_PER_S 1000
// settle time in sys_clk cycles, a longest time so it rounds down
`define PSS_SETTLE_CYC ((`PSS_SETTLE_MS * `PSS_CLK_HZ) / `PSS_MS_PER_S)
// field positions of the synchronised pin vector
`define PSS_PIN_PD 0
`define PSS_PIN_STRAP 1
`define PSS_PIN_HSEL 2
`define PSS_PIN_EXTREQ 3
`define PSS_PIN_GPIO 4
`define PSS_PIN_CPUREL 5
`define PSS_PIN_W 6
// pin reset value and settle count step
`define PSS_PIN_RST 6'h00
`define PSS_CNT_ONE 1
`endif

// file: verilog/pss_pkg.sv
package pss_pkg;
  // top level power states
  typedef enum logic [2:0] {
    PSS_OFF = 3'b000,
    PSS_HOST_OFF = 3'b001,
    PSS_SLEEP = 3'b010,
    PSS_WAKEUP = 3'b011,
    PSS_ON = 3'b100
  } pss_state_e;

  // inactivity reports from the subsystems
  typedef struct packed {
    logic mac;
    logic host_mailbox;
    logic cpu;
  } pss_sleep_req_s;

  // on-chip wakeup sources (host and gpio arrive separately)
  typedef struct packed {
    logic mac;
    logic low_freq_timer;
  } pss_wake_src_s;

  // reset outputs, all active high inside the struct
  typedef struct packed {
    logic blk;
    logic cpu;
    logic mac_cold;
    logic mac_warm;
  } pss_rst_s;
endpackage

// file: verilog/pss_sequencer.sv
`include "pss_params.svh"

module pss_sequencer import pss_pkg::*; #(
  parameter int NBLK = 4,
  parameter int CNT_W = 16,
  parameter logic [CNT_W-1:0] SETTLE_CYC = CNT_W'(`PSS_SETTLE_CYC)
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic host_clk,
  input wire logic host_rst_n,
  input wire logic chip_powerdown_n,
  input wire logic boot_strap_pin,
  input wire logic host_sel_strap,
  input wire logic ext_clk_req,
  input wire logic gpio_wake,
  input wire logic cpu_rst_release_pin,
  input wire logic host_wake_wr,
  input wire logic host_cpu_rst_clr_wr,
  input wire pss_sleep_req_s sleep_req,
  input wire pss_wake_src_s wake_src,
  input wire logic cpu_irq,
  input wire logic xtal_fitted,
  input wire logic xtal_stable,
  input wire logic pll_lock,
  input wire logic [CNT_W-1:0] settle_cfg,
  input wire logic [NBLK-1:0] clk_ctrl,
  input wire logic cpu_rst_hold_cfg,
  input wire logic mac_cold_rst_clr,
  input wire logic mac_warm_rst_clr,
  input wire logic fw_func_ready,
  input wire logic ext_lf_sel,
  output pss_state_e state,
  output pss_rst_s rst_out,
  output logic [NBLK-1:0] hs_clk_en,
  output logic cpu_clk_en,
  output logic xtal_drv_en,
  output logic pll_en,
  output logic clk_req_out,
  output logic ref_out_en,
  output logic sleep_clk_en,
  output logic osc_cal_en,
  output logic lf_ext_sel,
  output logic soc_pwr_en,
  output logic host_if_pwr_en,
  output logic host_if_idle,
  output logic sdio_en,
  output logic spi_en,
  output logic host_func_ready
);

  // pin inputs: two flops before any logic looks at them
  logic [`PSS_PIN_W-1:0] pin_s1;
  logic [`PSS_PIN_W-1:0] pin_s2;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_s1 <= `PSS_PIN_RST;
      pin_s2 <= `PSS_PIN_RST;
    end else begin
      pin_s1 <= {cpu_rst_release_pin, gpio_wake, ext_clk_req, host_sel_strap,
                 boot_strap_pin, chip_powerdown_n};
      pin_s2 <= pin_s1;
    end
  end

  logic pd_rel;
  logic strap_s;
  logic hsel_s;
  logic ext_req_s;
  logic gpio_s;
  logic cpu_rel_s;
  assign pd_rel = pin_s2[`PSS_PIN_PD];
  assign strap_s = pin_s2[`PSS_PIN_STRAP];
  assign hsel_s = pin_s2[`PSS_PIN_HSEL];
  assign ext_req_s = pin_s2[`PSS_PIN_EXTREQ];
  assign gpio_s = pin_s2[`PSS_PIN_GPIO];
  assign cpu_rel_s = pin_s2[`PSS_PIN_CPUREL];

  // host clock domain: writes become toggles so no pulse is lost
  logic func_ready;
  logic h_wake_tgl;
  logic h_clr_tgl;
  logic h_rdy1;
  logic h_rdy2;
  logic next_h_wake_tgl;
  logic next_h_clr_tgl;
  always_comb begin
    next_h_wake_tgl = h_wake_tgl ^ host_wake_wr;
    next_h_clr_tgl = h_clr_tgl ^ host_cpu_rst_clr_wr;
  end
  always_ff @(posedge host_clk) begin
    if (!host_rst_n) begin
      h_wake_tgl <= 1'b0;
      h_clr_tgl <= 1'b0;
      h_rdy1 <= 1'b0;
      h_rdy2 <= 1'b0;
      host_func_ready <= 1'b0;
    end else begin
      h_wake_tgl <= next_h_wake_tgl;
      h_clr_tgl <= next_h_clr_tgl;
      h_rdy1 <= func_ready;
      h_rdy2 <= h_rdy1;
      host_func_ready <= h_rdy2;
    end
  end

  // toggles into the sequencer clock; third flop gives the edge
  logic [2:0] wake_sy;
  logic [2:0] clr_sy;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wake_sy <= 3'h0;
      clr_sy <= 3'h0;
    end else begin
      wake_sy <= {wake_sy[1:0], h_wake_tgl};
      clr_sy <= {clr_sy[1:0], h_clr_tgl};
    end
  end

  logic host_wake_ev;
  logic host_clr_ev;
  assign host_wake_ev = wake_sy[2] ^ wake_sy[1];
  assign host_clr_ev = clr_sy[2] ^ clr_sy[1];

  // sequencer state
  logic [CNT_W-1:0] cnt;
  logic cold;
  logic [CNT_W-1:0] settle_lim;
  logic any_wake;
  logic all_idle;
  logic on_next;
  logic pwr_next;
  pss_state_e next_state;
  logic [CNT_W-1:0] next_cnt;
  logic next_cold;
  logic next_func_ready;
  pss_rst_s next_rst;
  logic [NBLK-1:0] next_hs_clk_en;
  logic next_cpu_clk_en;
  logic next_xtal_drv_en;
  logic next_pll_en;
  logic next_clk_req_out;
  logic next_sdio_en;

  // zero in the settle field selects the nominal settle time
  assign settle_lim = (settle_cfg == '0) ? SETTLE_CYC : settle_cfg;
  assign any_wake = wake_src.mac | wake_src.low_freq_timer | gpio_s | host_wake_ev;
  assign all_idle = sleep_req.mac & sleep_req.host_mailbox & sleep_req.cpu;

  // state transitions and the crystal, pll, clock request, reset and cpu clock controls
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cold = cold;
    next_sdio_en = sdio_en;
    next_pll_en = pll_en;
    next_xtal_drv_en = xtal_drv_en;
    case (state)
      PSS_OFF: begin
        next_cold = 1'b1;
        if (pd_rel) begin
          // strap levels are caught on the first cycle after release
          next_sdio_en = hsel_s;
          next_state = strap_s ? PSS_HOST_OFF : PSS_WAKEUP;
        end
      end
      PSS_HOST_OFF: begin
        if (host_wake_ev) begin
          next_state = PSS_WAKEUP;
        end
      end
      PSS_SLEEP: begin
        if (any_wake) begin
          next_state = PSS_WAKEUP;
        end
      end
      PSS_WAKEUP: begin
        // crystal first, pll only once it is stable, then settle count
        next_xtal_drv_en = 1'b1;
        if (xtal_stable) begin
          next_pll_en = 1'b1;
        end
        if (pll_en && cnt < settle_lim) begin
          next_cnt = cnt + CNT_W'(`PSS_CNT_ONE);
        end
        if (pll_en && pll_lock && cnt >= settle_lim) begin
          next_state = PSS_ON;
        end
      end
      PSS_ON: begin
        next_cnt = '0;
        // a pending wake source vetoes sleep so it is not missed
        if (all_idle && !any_wake) begin
          next_state = PSS_SLEEP;
        end
      end
      default: begin
        next_state = PSS_OFF;
      end
    endcase
    if (!pd_rel) begin
      next_state = PSS_OFF;
    end
    on_next = (next_state == PSS_ON);
    pwr_next = (next_state != PSS_OFF) && (next_state != PSS_HOST_OFF);
    if (next_state != PSS_WAKEUP) begin
      next_cnt = '0;
      next_pll_en = on_next;
      next_xtal_drv_en = on_next;
    end
    if (on_next) begin
      next_cold = 1'b0;
    end
    // ext request keeps the crystal driver alive for a sharing peer
    if (xtal_fitted && ext_req_s) begin
      next_xtal_drv_en = 1'b1;
    end
    if (!xtal_fitted) begin
      next_xtal_drv_en = 1'b0;
    end
    next_clk_req_out = (next_state == PSS_WAKEUP) || on_next;
    if (!xtal_fitted && ext_req_s) begin
      next_clk_req_out = 1'b1;
    end
    // resets: cold-entry values first, then clears, then the power-off set, so that set always wins
    next_rst = rst_out;
    if (cold && on_next) begin
      next_rst.blk = 1'b0;
      next_rst.cpu = cpu_rst_hold_cfg;
    end
    if (cpu_rel_s || host_clr_ev) begin
      next_rst.cpu = 1'b0;
    end
    if (mac_cold_rst_clr) begin
      next_rst.mac_cold = 1'b0;
    end
    if (mac_warm_rst_clr) begin
      next_rst.mac_warm = 1'b0;
    end
    if (!pwr_next) begin
      next_rst = '1;
    end
    // cpu clock: boot run on cold entry, afterwards only an interrupt
    next_cpu_clk_en = cpu_clk_en;
    if (next_state == PSS_SLEEP || !pwr_next) begin
      next_cpu_clk_en = 1'b0;
    end
    if (on_next && (cold || cpu_irq)) begin
      next_cpu_clk_en = 1'b1;
    end
    next_func_ready = fw_func_ready && pwr_next;
  end

  // per-block fast clock gates follow the control mask in on only
  genvar gi;
  generate
    for (gi = 0; gi < NBLK; gi++) begin : g_clk
      assign next_hs_clk_en[gi] = on_next & clk_ctrl[gi];
    end
  endgenerate

  // registers of the sequencer; all outputs but host_func_ready leave from here
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= PSS_OFF;
      cnt <= '0;
      cold <= 1'b1;
      func_ready <= 1'b0;
      rst_out <= '1;
      hs_clk_en <= '0;
      cpu_clk_en <= 1'b0;
      xtal_drv_en <= 1'b0;
      pll_en <= 1'b0;
      clk_req_out <= 1'b0;
      ref_out_en <= 1'b0;
      sleep_clk_en <= 1'b0;
      osc_cal_en <= 1'b0;
      lf_ext_sel <= 1'b0;
      soc_pwr_en <= 1'b0;
      host_if_pwr_en <= 1'b0;
      host_if_idle <= 1'b1;
      sdio_en <= 1'b0;
      spi_en <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cold <= next_cold;
      func_ready <= next_func_ready;
      rst_out <= next_rst;
      hs_clk_en <= next_hs_clk_en;
      cpu_clk_en <= next_cpu_clk_en;
      xtal_drv_en <= next_xtal_drv_en;
      pll_en <= next_pll_en;
      clk_req_out <= next_clk_req_out;
      ref_out_en <= ext_req_s;
      sleep_clk_en <= (next_state != PSS_OFF);
      osc_cal_en <= on_next && !ext_lf_sel;
      lf_ext_sel <= ext_lf_sel;
      soc_pwr_en <= pwr_next;
      host_if_pwr_en <= (next_state != PSS_OFF);
      host_if_idle <= (next_state == PSS_SLEEP) || (next_state == PSS_OFF);
      sdio_en <= next_sdio_en && (next_state != PSS_OFF);
      spi_en <= !next_sdio_en && (next_state != PSS_OFF);
    end
  end

endmodule

// file: verif/pss_sequencer_sva.sv
module pss_sequencer_sva import pss_pkg::*; #(
  parameter int NBLK = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic chip_powerdown_n,
  input wire pss_sleep_req_s sleep_req,
  input wire pss_wake_src_s wake_src,
  input wire logic cpu_irq,
  input wire logic pll_lock,
  input wire logic mac_cold_rst_clr,
  input wire pss_state_e state,
  input wire pss_rst_s rst_out,
  input wire logic [NBLK-1:0] hs_clk_en,
  input wire logic cpu_clk_en,
  input wire logic pll_en,
  input wire logic clk_req_out,
  input wire logic sleep_clk_en,
  input wire logic host_if_idle
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // the two steps into sleep and out of the settle phase
  sequence into_sleep; state != PSS_SLEEP ##1 state == PSS_SLEEP; endsequence
  sequence wake_to_on; state == PSS_WAKEUP ##1 state == PSS_ON; endsequence
  // pin goes through two flops, so off lands on the third edge
  pd_off_a: assert property ((!chip_powerdown_n) [*3] |=> state == PSS_OFF && !sleep_clk_en)
    else $error("powerdown missed off");
  wake_gate_a: assert property (state == PSS_WAKEUP |-> hs_clk_en == '0)
    else $error("wakeup leaked fast clock");
  // resets survive a sleep, so only the cold release is tied to the wakeup exit
  blk_rel_a: assert property ($fell(rst_out.blk) |->
    state == PSS_ON && $past(state) == PSS_WAKEUP) else $error("block reset released early");
  on_lock_a: assert property (wake_to_on |-> $past(pll_lock))
    else $error("on without lock");
  req_on_a: assert property (state inside {PSS_WAKEUP, PSS_ON} |-> clk_req_out)
    else $error("clock request low");
  sleep_gate_a: assert property (into_sleep |-> $past(&sleep_req) && hs_clk_en == '0
    && !pll_en && host_if_idle) else $error("bad sleep entry");
  // a powerdown already inside the pin flops wins over the wake
  wake_a: assert property (state == PSS_SLEEP && wake_src != '0
    && $past(chip_powerdown_n, 2) |=> state == PSS_WAKEUP) else $error("wake source ignored");
  mac_hold_a: assert property (rst_out.mac_cold && !mac_cold_rst_clr |=> rst_out.mac_cold)
    else $error("mac reset dropped");
  cpu_irq_a: assert property ($rose(cpu_clk_en) && $past(state) == PSS_ON |-> $past(cpu_irq))
    else $error("cpu clock without irq");
endmodule

bind pss_sequencer pss_sequencer_sva #(.NBLK(NBLK)) pss_sequencer_sva_i (.*);

// file: verif/pss_host_model.sv
module pss_host_model (
  output logic host_clk,
  output logic host_rst_n,
  output logic host_wake_wr,
  output logic host_cpu_rst_clr_wr,
  input wire logic host_func_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  // host clock is its own free 80 ns clock, offset from sys_clk
  initial begin
    host_clk = 1'b0;
    host_rst_n = 1'b0;
    host_wake_wr = 1'b0;
    host_cpu_rst_clr_wr = 1'b0;
    #7;
    forever #40 host_clk = ~host_clk;
  end
  initial begin
    repeat (3) @(posedge host_clk);
    #1 host_rst_n = 1'b1;
  end
  // one-cycle register write; callers leave long gaps so toggles never merge
  task automatic wr(input logic clr);
    @(posedge host_clk);
    #1 if (clr) host_cpu_rst_clr_wr = 1'b1; else host_wake_wr = 1'b1;
    @(posedge host_clk);
    #1 {host_wake_wr, host_cpu_rst_clr_wr} = 2'b00;
  endtask
  // poll the ready flag before any function command
  task automatic ready(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 16 && ok !== 1'b1; i++) begin
      // look half a period after the flop has settled
      @(negedge host_clk);
      ok = host_func_ready;
    end
  endtask
endmodule

// file: verif/tb.sv
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, a); end end

module tb import pss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, rst_n = 1'b0, chip_powerdown_n = 1'b0, boot_strap_pin = 1'b1;
  logic host_sel_strap = 1'b1, gpio_wake = 1'b0, cpu_irq = 1'b0, xtal_stable = 1'b0;
  logic pll_lock = 1'b0, cpu_rst_hold_cfg = 1'b1, mac_cold_rst_clr = 1'b0;
  logic mac_warm_rst_clr = 1'b0, fw_func_ready = 1'b0, ok;
  logic ext_clk_req = 1'b0, cpu_rst_release_pin = 1'b0, ext_lf_sel = 1'b0;
  logic host_clk, host_rst_n, host_wake_wr, host_cpu_rst_clr_wr, host_func_ready;
  logic [3:0] clk_ctrl = 4'ha, hs_clk_en;
  pss_sleep_req_s sleep_req = '0;
  pss_wake_src_s wake_src = '0;
  pss_state_e state;
  pss_rst_s rst_out;
  logic cpu_clk_en, xtal_drv_en, pll_en, clk_req_out, ref_out_en, sleep_clk_en, osc_cal_en;
  logic lf_ext_sel, soc_pwr_en, host_if_pwr_en, host_if_idle, sdio_en, spi_en;
  int n_mismatch = 0, n_checks = 0;
  // short settle count keeps each wakeup to a few cycles
  always #20 sys_clk = ~sys_clk;
  pss_sequencer #(.SETTLE_CYC(16'h8)) pss_sequencer_i (.*, .xtal_fitted(1'b1),
    .settle_cfg(16'h0));
  pss_host_model pss_host_model_i (.*);
  task automatic go(input pss_state_e s, input string nm);
    for (int i = 0; i < 300 && state !== s; i++) @(negedge sys_clk);
    `CHK(nm, s, state)
  endtask
  // cold boot waits for the host, then crystal, pll and lock in order
  task automatic boot();
    chip_powerdown_n = 1'b1;
    go(PSS_HOST_OFF, "hostwait");
    repeat (20) @(negedge sys_clk);
    `CHK("idle", 4'h2, {state, soc_pwr_en})
    `CHK("blk rst", 1'b1, rst_out.blk)
    `CHK("host sel", 2'b10, {sdio_en, spi_en})
    pss_host_model_i.wr(1'b0);
    go(PSS_WAKEUP, "wake");
    repeat (5) @(negedge sys_clk);
    `CHK("pll early", 2'b10, {xtal_drv_en, pll_en})
    xtal_stable = 1'b1;
    repeat (12) @(negedge sys_clk);
    `CHK("no lock", 4'h7, {state, pll_en})
    pll_lock = 1'b1;
    go(PSS_ON, "on");
    `CHK("blk rst", 1'b0, rst_out.blk)
    `CHK("hs clk", clk_ctrl, hs_clk_en)
  endtask
  // each held reset clears only on its own request
  task automatic resets();
    `CHK("cpu held", 4'h7, rst_out)
    `CHK("ready early", 1'b0, host_func_ready)
    pss_host_model_i.wr(1'b1);
    @(negedge sys_clk);
    mac_cold_rst_clr = 1'b1;
    @(negedge sys_clk);
    mac_cold_rst_clr = 1'b0;
    repeat (8) @(negedge sys_clk);
    `CHK("cold clr", 4'h1, rst_out)
    mac_warm_rst_clr = 1'b1;
    @(negedge sys_clk);
    mac_warm_rst_clr = 1'b0;
    fw_func_ready = 1'b1;
    pss_host_model_i.ready(ok);
    `CHK("ready", 5'h10, {ok, rst_out})
  endtask
  // sleep clock source and the per-block mask follow their inputs while on
  task automatic share();
    ext_lf_sel = 1'b1;
    clk_ctrl = 4'h5;
    repeat (2) @(negedge sys_clk);
    `CHK("lf ext", 3'h6, {lf_ext_sel, host_if_pwr_en, osc_cal_en})
    `CHK("hs mask", 4'h5, hs_clk_en)
    ext_lf_sel = 1'b0;
    @(negedge sys_clk);
    `CHK("cal on", 1'b1, osc_cal_en)
  endtask
  // a busy cpu blocks sleep; then every wake source in turn
  task automatic sleeps();
    sleep_req = 3'b110;
    repeat (6) @(negedge sys_clk);
    `CHK("busy", PSS_ON, state)
    for (int k = 0; k < 4; k++) begin
      sleep_req = 3'b111;
      go(PSS_SLEEP, "sleep");
      `CHK("sleep clk", 4'h1, {pll_en, clk_req_out, xtal_drv_en, sleep_clk_en})
      sleep_req = 3'b000;
      if (k == 0) wake_src.mac = 1'b1;
      else if (k == 1) wake_src.low_freq_timer = 1'b1;
      else if (k == 2) gpio_wake = 1'b1;
      else pss_host_model_i.wr(1'b0);
      go(PSS_WAKEUP, "woken");
      wake_src = '0;
      gpio_wake = 1'b0;
      go(PSS_ON, "back on");
      `CHK("cpu gated", 1'b0, cpu_clk_en)
      cpu_irq = 1'b1;
      repeat (3) @(negedge sys_clk);
      `CHK("cpu runs", 1'b1, cpu_clk_en)
      cpu_irq = 1'b0;
    end
  endtask
  // powerdown forgets everything; strap low then bypasses host-wait
  task automatic pdown();
    chip_powerdown_n = 1'b0;
    boot_strap_pin = 1'b0;
    host_sel_strap = 1'b0;
    ext_clk_req = 1'b1;
    repeat (4) @(negedge sys_clk);
    `CHK("off", 8'h0f, {state, sleep_clk_en, rst_out})
    `CHK("off share", 4'hc, {ref_out_en, xtal_drv_en, host_if_pwr_en, soc_pwr_en})
    ext_clk_req = 1'b0;
    chip_powerdown_n = 1'b1;
    for (int i = 0; i < 20 && state === PSS_OFF; i++) @(negedge sys_clk);
    `CHK("skip", PSS_WAKEUP, state)
    `CHK("spi sel", 2'b01, {sdio_en, spi_en})
    go(PSS_ON, "reboot");
    `CHK("reboot rst", 4'h7, rst_out)
    cpu_rst_release_pin = 1'b1;
    repeat (4) @(negedge sys_clk);
    `CHK("pin rel", 4'h3, rst_out)
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // the whole run is under 2000 sys_clk cycles
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    boot();
    resets();
    share();
    sleeps();
    pdown();
    results();
  end
endmodule
